/* cprc_defs.vh */
`ifndef CPRC_DEFS_VH
`define CPRC_DEFS_VH

// register byte offsets
`define CPRC_MAINSEL     8'h00
`define CPRC_PLLCTRL     8'h04
`define CPRC_PLLSTAT     8'h08
`define CPRC_CLKOUTSEL   8'h0c
`define CPRC_CLKEN       8'h10
`define CPRC_PERDIV      8'h14
`define CPRC_PCON        8'h18
`define CPRC_STARTEN     8'h1c
`define CPRC_WDMOD       8'h20
`define CPRC_WDTC        8'h24
`define CPRC_WDFEED      8'h28
`define CPRC_WDTV        8'h2c
`define CPRC_RSTSTAT     8'h30

// clock source codes
`define CPRC_SRC_IRC     2'h0
`define CPRC_SRC_SYS     2'h1
`define CPRC_SRC_WDO     2'h2
`define CPRC_SRC_PLL     2'h3
`define CPRC_SRC_MAIN    2'h3

// pll control fields
`define CPRC_PLL_M_LSB   0
`define CPRC_PLL_M_MSB   4
`define CPRC_PLL_P_LSB   5
`define CPRC_PLL_P_MSB   6
`define CPRC_PLL_ON_BIT  7

// power control fields
`define CPRC_PCON_DEEP   0
`define CPRC_PCON_KIRC   1
`define CPRC_PCON_KBOD   2
`define CPRC_PCON_KWDT   3
`define CPRC_PCON_SYSON  4
`define CPRC_PCON_WDOON  5
`define CPRC_PCON_RST    6'h04

// watchdog mode fields
`define CPRC_WD_EN       0
`define CPRC_WD_IRQRESP  1
`define CPRC_WD_TOF      2
`define CPRC_WD_CLKSEL   3

// watchdog constants
`define CPRC_WDTC_MIN    24'h0000ff
`define CPRC_WDTC_RST    24'h0000ff
`define CPRC_FEED_1      8'haa
`define CPRC_FEED_2      8'h55

// reset status fields
`define CPRC_RS_POR      0
`define CPRC_RS_PIN      1
`define CPRC_RS_WDT      2
`define CPRC_RS_BOD      3

// timing
`define CPRC_CLK_MHZ     25
`define CPRC_PIN_RST_NS  50
`define CPRC_PIN_RST_CYC ((`CPRC_PIN_RST_NS * `CPRC_CLK_MHZ) / 1000)
`define CPRC_PLL_LOCK_US 100
`define CPRC_PLL_LOCK_CYC (`CPRC_PLL_LOCK_US * `CPRC_CLK_MHZ)
`define CPRC_RST_HOLD    4'h4
`define CPRC_BOOT_ADDR   32'h00000000

`endif

/* cprc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module cprc_monitor #(
    parameter NSTART = 13,
    parameter NPER   = 16
) (
    input wire logic              mclk_i,
    input wire logic              rst_i,
    input wire logic              reset_pin_n_i,
    input wire logic              brownout_i,
    input wire logic              sleep_req_i,
    input wire logic              irq_pending_i,
    input wire logic              chip_rst_o,
    input wire logic              flash_init_o,
    input wire logic [31:0]       boot_addr_o,
    input wire logic              core_clk_en_o,
    input wire logic [1:0]        main_sel_o,
    input wire logic              pll_pd_o,
    input wire logic              pll_bypass_o,
    input wire logic [NPER-1:0]   periph_clk_en_o,
    input wire logic              analog_pd_o,
    input wire logic              internal_rc_en_o,
    input wire logic [NSTART-1:0] start_irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // registered outputs need one edge of reset before they show defaults
    sequence s_rst_held;
        chip_rst_o && $past(chip_rst_o);
    endsequence
    sequence s_sleep_req;
        sleep_req_i && core_clk_en_o && !chip_rst_o && !irq_pending_i ##1 !irq_pending_i;
    endsequence

    chk_boot_vector: assert property (boot_addr_o == 32'h00000000)
        else $error("boot address not zero");
    chk_reset_clock: assert property (s_rst_held |-> main_sel_o == 2'h0 && internal_rc_en_o && !core_clk_en_o)
        else $error("clock source not internal rc in reset");
    chk_reset_pll: assert property (s_rst_held |-> pll_pd_o && pll_bypass_o)
        else $error("pll not off and bypassed in reset");
    chk_flash_init: assert property (flash_init_o |-> chip_rst_o ##1 !flash_init_o)
        else $error("flash init outside chip reset");
    chk_pin_reset: assert property (!reset_pin_n_i |-> ##[1:4] chip_rst_o)
        else $error("reset pin low without chip reset");
    chk_brownout_reset: assert property (brownout_i |-> ##[1:4] chip_rst_o)
        else $error("brownout without chip reset");
    chk_sleep_entry: assert property (s_sleep_req |-> ##[1:2] !core_clk_en_o)
        else $error("core clock kept after sleep request");
    chk_sleep_wake: assert property (!core_clk_en_o && !chip_rst_o && irq_pending_i
        |-> ##[1:4] core_clk_en_o)
        else $error("no wake on pending interrupt");
    chk_deep_periph: assert property (analog_pd_o |-> periph_clk_en_o == '0)
        else $error("peripheral clock in deep sleep");
    chk_start_pulse: assert property (start_irq_o != '0 |=> (start_irq_o & $past(start_irq_o)) == '0)
        else $error("start interrupt longer than one cycle");
endmodule // cprc_monitor

bind cprc_top cprc_monitor #(.NSTART(NSTART), .NPER(NPER)) cprc_monitor_inst (
    .mclk_i, .rst_i, .reset_pin_n_i, .brownout_i, .sleep_req_i, .irq_pending_i,
    .chip_rst_o, .flash_init_o, .boot_addr_o, .core_clk_en_o, .main_sel_o, .pll_pd_o,
    .pll_bypass_o, .periph_clk_en_o, .analog_pd_o, .internal_rc_en_o, .start_irq_o
);
`default_nettype wire

/* cprc_note_placeholder_unused.v */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* cprc_top.v */
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cprc_defs.vh"

module cprc_top #(
    parameter NSTART = 13,
    parameter NPER   = 16,
    parameter NDIV   = 2
) (
    input  wire              mclk_i,
    input  wire              rst_i,
    input  wire [7:0]        addr_i,
    input  wire [31:0]       wdata_i,
    input  wire              wr_i,
    input  wire              rd_i,
    output reg  [31:0]       rdata_o,
    input  wire              reset_pin_n_i,
    input  wire              brownout_i,
    input  wire              internal_rc_clock_i,
    input  wire              sysosc_clock_i,
    input  wire              watchdog_osc_i,
    input  wire [NSTART-1:0] start_pin_i,
    input  wire              sleep_req_i,
    input  wire              irq_pending_i,
    output reg               chip_rst_o,
    output reg               flash_init_o,
    output reg  [31:0]       boot_addr_o,
    output reg               core_clk_en_o,
    output reg  [1:0]        main_sel_o,
    output reg               pll_pd_o,
    output reg               pll_bypass_o,
    output reg  [4:0]        pll_msel_o,
    output reg  [1:0]        pll_psel_o,
    output reg               clock_out_pin_o,
    output reg  [NPER-1:0]   periph_clk_en_o,
    output reg  [NDIV-1:0]   periph_tick_o,
    output reg               analog_pd_o,
    output reg               internal_rc_en_o,
    output reg               sysosc_en_o,
    output reg               watchdog_osc_en_o,
    output reg               brownout_monitor_en_o,
    output reg  [NSTART-1:0] start_irq_o,
    output reg               wd_irq_o
);

    localparam ST_ACT = 2'h0;
    localparam ST_SLP = 2'h1;
    localparam ST_DSL = 2'h2;
    localparam NSYNC  = NSTART + 5;
    localparam integer PLL_LOCK_N = `CPRC_PLL_LOCK_CYC;
    localparam [11:0] PLL_LOCK = PLL_LOCK_N[11:0];
    // reset pin idles high; a cleared flop would fake a pin reset after power-on
    localparam [NSYNC-1:0] SYNC_IDLE = {{(NSYNC-4){1'b0}}, 4'h8};

    // two-flop synchronisers for all pins and foreign oscillators
    reg  [NSYNC-1:0] sync_a;
    reg  [NSYNC-1:0] sync_b;
    reg  [NSYNC-1:0] sync_q;
    wire [NSYNC-1:0] raw_in = {start_pin_i, brownout_i, reset_pin_n_i,
                               watchdog_osc_i, sysosc_clock_i, internal_rc_clock_i};
    wire             irc_s  = sync_b[0];
    wire             sys_s  = sync_b[1];
    wire             wdo_s  = sync_b[2];
    wire             pin_s  = sync_b[3];
    wire             bod_s  = sync_b[4];
    wire [NSTART-1:0] st_s  = sync_b[NSYNC-1:5];
    wire [NSTART-1:0] st_q  = sync_q[NSYNC-1:5];

    always @(posedge mclk_i) begin
        if (rst_i) begin
            sync_a <= SYNC_IDLE;
            sync_b <= SYNC_IDLE;
            sync_q <= SYNC_IDLE;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
            sync_q <= sync_b;
        end
    end

    // chip reset gathering
    reg        wd_fire;
    reg  [3:0] hold;
    reg  [3:0] rststat;
    wire       pin_rst  = ~pin_s & ~rst_i;
    wire       crst_src = rst_i | pin_rst | (bod_s & ~rst_i) | wd_fire;
    wire       ir       = rst_i | chip_rst_o;
    wire       wr_rs    = wr_i & (addr_i == `CPRC_RSTSTAT);

    // one sample of a 50 ns low pulse is enough, so no filter here
    always @(posedge mclk_i) begin
        if (rst_i) begin
            hold         <= `CPRC_RST_HOLD;
            chip_rst_o   <= 1'b1;
            flash_init_o <= 1'b0;
            rststat      <= 4'h1;
        end else begin
            if (crst_src)
                hold <= `CPRC_RST_HOLD;
            else if (hold != 4'h0)
                hold <= hold - 4'h1;
            chip_rst_o   <= crst_src | (hold > 4'h1);
            flash_init_o <= crst_src & ~chip_rst_o;
            rststat[`CPRC_RS_POR] <= rststat[`CPRC_RS_POR] & ~(wr_rs & wdata_i[0]);
            rststat[`CPRC_RS_PIN] <= pin_rst | (rststat[1] & ~(wr_rs & wdata_i[1]));
            rststat[`CPRC_RS_WDT] <= wd_fire | (rststat[2] & ~(wr_rs & wdata_i[2]));
            rststat[`CPRC_RS_BOD] <= bod_s | (rststat[3] & ~(wr_rs & wdata_i[3]));
        end
    end

    // software registers, all restored while chip reset stands
    reg  [1:0]        mainsel;
    reg  [7:0]        pllctrl;
    reg  [1:0]        clkoutsel;
    reg  [NPER-1:0]   clken;
    reg  [8*NDIV-1:0] perdiv;
    reg  [5:0]        pcon;
    reg  [NSTART-1:0] starten;
    reg  [3:0]        wdmod;
    reg  [23:0]       wdtc;
    reg  [23:0]       wdtv;
    reg  [1:0]        wdpre;
    reg               feed_armed;
    reg               pll_lock;
    reg  [11:0]       lock_cnt;
    reg  [1:0]        pstate;
    reg               wd_src_q;
    reg               ptog;

    wire wr_wd   = wr_i & (addr_i == `CPRC_WDFEED);
    wire feed_ok = wr_wd & feed_armed & (wdata_i[7:0] == `CPRC_FEED_2);
    // any write after the first feed byte that is not the second byte breaks the feed
    wire feed_bad = wdmod[`CPRC_WD_EN] &
                    ((wr_i & feed_armed & ~feed_ok) |
                     (wr_wd & ~feed_armed & (wdata_i[7:0] != `CPRC_FEED_1)));
    wire wd_src  = wdmod[`CPRC_WD_CLKSEL] ? wdo_s : irc_s;
    wire wd_tick = wd_src & ~wd_src_q;
    wire wd_dec  = wd_tick & (wdpre == 2'h3);
    wire wd_tout = wdmod[`CPRC_WD_EN] & wd_dec & (wdtv == 24'h000000);
    wire wd_evt  = wd_tout | feed_bad;
    wire deep    = (pstate == ST_DSL);
    wire pll_on  = pllctrl[`CPRC_PLL_ON_BIT];
    wire [NSTART-1:0] st_hit = st_s & ~st_q & starten;
    wire wr_tof  = wr_i & (addr_i == `CPRC_WDMOD) & ~wdata_i[`CPRC_WD_TOF];

    always @(posedge mclk_i) begin
        if (ir) begin
            mainsel    <= `CPRC_SRC_IRC;
            pllctrl    <= 8'h00;
            clkoutsel  <= `CPRC_SRC_IRC;
            clken      <= {NPER{1'b1}};
            perdiv     <= {(8*NDIV){1'b0}};
            pcon       <= `CPRC_PCON_RST;
            starten    <= {NSTART{1'b0}};
            wdmod      <= 4'h0;
            wdtc       <= `CPRC_WDTC_RST;
            feed_armed <= 1'b0;
        end else begin
            if (wr_i) begin
                case (addr_i)
                    `CPRC_MAINSEL:   mainsel   <= wdata_i[1:0];
                    `CPRC_PLLCTRL:   pllctrl   <= wdata_i[7:0];
                    `CPRC_CLKOUTSEL: clkoutsel <= wdata_i[1:0];
                    `CPRC_CLKEN:     clken     <= wdata_i[NPER-1:0];
                    `CPRC_PERDIV:    perdiv    <= wdata_i[8*NDIV-1:0];
                    `CPRC_PCON:      pcon      <= wdata_i[5:0];
                    `CPRC_STARTEN:   starten   <= wdata_i[NSTART-1:0];
                    `CPRC_WDTC: begin
                        if (wdata_i[23:0] < `CPRC_WDTC_MIN)
                            wdtc <= `CPRC_WDTC_MIN;
                        else
                            wdtc <= wdata_i[23:0];
                    end
                    default: ;
                endcase
            end
            // enable can only be set; only a reset turns the watchdog off
            if (wr_i & (addr_i == `CPRC_WDMOD)) begin
                wdmod[`CPRC_WD_EN]     <= wdmod[`CPRC_WD_EN] | wdata_i[`CPRC_WD_EN];
                wdmod[`CPRC_WD_IRQRESP] <= wdata_i[`CPRC_WD_IRQRESP];
                wdmod[`CPRC_WD_CLKSEL]  <= wdata_i[`CPRC_WD_CLKSEL];
            end
            // timeout flag: hardware set wins over software clear
            wdmod[`CPRC_WD_TOF] <= wd_evt | (wdmod[`CPRC_WD_TOF] & ~wr_tof);
            if (wr_wd & (wdata_i[7:0] == `CPRC_FEED_1) & ~feed_armed)
                feed_armed <= 1'b1;
            else if (wr_i)
                feed_armed <= 1'b0;
        end
    end

    // watchdog counter and response
    always @(posedge mclk_i) begin
        if (ir) begin
            wdtv     <= `CPRC_WDTC_RST;
            wdpre    <= 2'h0;
            wd_src_q <= 1'b0;
            wd_fire  <= 1'b0;
            wd_irq_o <= 1'b0;
        end else begin
            wd_src_q <= wd_src;
            if (wd_tick)
                wdpre <= wdpre + 2'h1;
            if (feed_ok | wd_tout)
                wdtv <= wdtc;
            else if (wdmod[`CPRC_WD_EN] & wd_dec)
                wdtv <= wdtv - 24'h000001;
            wd_fire  <= wd_evt & ~wdmod[`CPRC_WD_IRQRESP];
            wd_irq_o <= (wd_evt | (wdmod[`CPRC_WD_TOF] & ~wr_tof)) &
                        wdmod[`CPRC_WD_IRQRESP];
        end
    end

    // pll lock timer; software waits on the status bit before selecting it
    always @(posedge mclk_i) begin
        if (ir) begin
            lock_cnt <= 12'h000;
            pll_lock <= 1'b0;
        end else if (~pll_on | deep | (wr_i & (addr_i == `CPRC_PLLCTRL))) begin
            lock_cnt <= 12'h000;
            pll_lock <= 1'b0;
        end else if (lock_cnt == PLL_LOCK - 12'h001) begin
            pll_lock <= 1'b1;
        end else begin
            lock_cnt <= lock_cnt + 12'h001;
        end
    end

    // power modes
    always @(posedge mclk_i) begin
        if (ir) begin
            pstate <= ST_ACT;
        end else begin
            case (pstate)
                ST_ACT: begin
                    if (sleep_req_i)
                        pstate <= pcon[`CPRC_PCON_DEEP] ? ST_DSL : ST_SLP;
                end
                ST_SLP: begin
                    if (irq_pending_i)
                        pstate <= ST_ACT;
                end
                ST_DSL: begin
                    if ((|st_hit) | wd_irq_o | irq_pending_i)
                        pstate <= ST_ACT;
                end
                default: pstate <= ST_ACT;
            endcase
        end
    end

    // peripheral dividers, tick period is div value cycles, zero stops it
    reg [8*NDIV-1:0] pdcnt;
    integer i;
    always @(posedge mclk_i) begin
        if (ir) begin
            pdcnt         <= {(8*NDIV){1'b0}};
            periph_tick_o <= {NDIV{1'b0}};
        end else begin
            for (i = 0; i < NDIV; i = i + 1) begin
                if ((perdiv[8*i +: 8] == 8'h00) | ~clken[i] | deep) begin
                    pdcnt[8*i +: 8]  <= 8'h00;
                    periph_tick_o[i] <= 1'b0;
                end else if (pdcnt[8*i +: 8] >= perdiv[8*i +: 8] - 8'h01) begin
                    pdcnt[8*i +: 8]  <= 8'h00;
                    periph_tick_o[i] <= 1'b1;
                end else begin
                    pdcnt[8*i +: 8]  <= pdcnt[8*i +: 8] + 8'h01;
                    periph_tick_o[i] <= 1'b0;
                end
            end
        end
    end

    // main clock level seen at the output pin; the pll itself is outside
    reg main_lvl;
    always @* begin
        case (mainsel)
            `CPRC_SRC_IRC: main_lvl = irc_s;
            `CPRC_SRC_SYS: main_lvl = sys_s;
            `CPRC_SRC_WDO: main_lvl = wdo_s;
            default:       main_lvl = ptog;
        endcase
    end

    // outputs, all registered
    always @(posedge mclk_i) begin
        if (ir) begin
            ptog                  <= 1'b0;
            boot_addr_o           <= `CPRC_BOOT_ADDR;
            core_clk_en_o         <= 1'b0;
            main_sel_o            <= `CPRC_SRC_IRC;
            pll_pd_o              <= 1'b1;
            pll_bypass_o          <= 1'b1;
            pll_msel_o            <= 5'h00;
            pll_psel_o            <= 2'h0;
            clock_out_pin_o       <= 1'b0;
            periph_clk_en_o       <= {NPER{1'b0}};
            analog_pd_o           <= 1'b0;
            internal_rc_en_o      <= 1'b1;
            sysosc_en_o           <= 1'b0;
            watchdog_osc_en_o     <= 1'b0;
            brownout_monitor_en_o <= 1'b1;
            start_irq_o           <= {NSTART{1'b0}};
        end else begin
            ptog          <= ~ptog;
            boot_addr_o   <= `CPRC_BOOT_ADDR;
            core_clk_en_o <= (pstate == ST_ACT);
            main_sel_o    <= mainsel;
            pll_pd_o      <= ~pll_on | deep;
            pll_bypass_o  <= ~pll_on;
            pll_msel_o    <= pllctrl[`CPRC_PLL_M_MSB:`CPRC_PLL_M_LSB];
            pll_psel_o    <= pllctrl[`CPRC_PLL_P_MSB:`CPRC_PLL_P_LSB];
            case (clkoutsel)
                `CPRC_SRC_IRC: clock_out_pin_o <= irc_s;
                `CPRC_SRC_SYS: clock_out_pin_o <= sys_s;
                `CPRC_SRC_WDO: clock_out_pin_o <= wdo_s;
                default:       clock_out_pin_o <= main_lvl;
            endcase
            periph_clk_en_o       <= clken & {NPER{~deep}};
            analog_pd_o           <= deep;
            internal_rc_en_o      <= ~deep | pcon[`CPRC_PCON_KIRC];
            sysosc_en_o           <= pcon[`CPRC_PCON_SYSON] & ~deep;
            watchdog_osc_en_o     <= pcon[`CPRC_PCON_WDOON] &
                                     (~deep | pcon[`CPRC_PCON_KWDT]);
            brownout_monitor_en_o <= ~deep | pcon[`CPRC_PCON_KBOD];
            start_irq_o           <= st_hit;
        end
    end

    // register read, data one cycle after the strobe
    always @(posedge mclk_i) begin
        if (ir) begin
            rdata_o <= 32'h00000000;
        end else if (rd_i) begin
            case (addr_i)
                `CPRC_MAINSEL:   rdata_o <= {30'h0, mainsel};
                `CPRC_PLLCTRL:   rdata_o <= {24'h0, pllctrl};
                `CPRC_PLLSTAT:   rdata_o <= {31'h0, pll_lock};
                `CPRC_CLKOUTSEL: rdata_o <= {30'h0, clkoutsel};
                `CPRC_CLKEN:     rdata_o <= {{(32-NPER){1'b0}}, clken};
                `CPRC_PERDIV:    rdata_o <= {{(32-8*NDIV){1'b0}}, perdiv};
                `CPRC_PCON:      rdata_o <= {22'h0, pstate, 2'h0, pcon};
                `CPRC_STARTEN:   rdata_o <= {{(32-NSTART){1'b0}}, starten};
                `CPRC_WDMOD:     rdata_o <= {28'h0, wdmod};
                `CPRC_WDTC:      rdata_o <= {8'h0, wdtc};
                `CPRC_WDTV:      rdata_o <= {8'h0, wdtv};
                `CPRC_RSTSTAT:   rdata_o <= {28'h0, rststat};
                default:         rdata_o <= 32'h00000000;
            endcase
        end else begin
            rdata_o <= 32'h00000000;
        end
    end

endmodule // cprc_top
`default_nettype wire

/* cprc_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cprc_defs.vh"
module cprc_top_bench;
    logic        mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, v, e;
    logic        reset_pin_n_i = 1'b1, brownout_i = 1'b0, sleep_req_i = 1'b0;
    logic        internal_rc_clock_i = 1'b0, sysosc_clock_i = 1'b0, watchdog_osc_i = 1'b0;
    logic        irq_pending_i = 1'b0, irc_run = 1'b0;
    logic [12:0] start_pin_i = 13'h0, st_last = 13'h0;
    logic [1:0]  irc_ph = 2'h0;
    wire  [31:0] rdata_o, boot_addr_o;
    wire  [1:0]  main_sel_o, pll_psel_o, periph_tick_o;
    wire  [4:0]  pll_msel_o;
    wire  [15:0] periph_clk_en_o;
    wire  [12:0] start_irq_o;
    wire         chip_rst_o, flash_init_o, core_clk_en_o, pll_pd_o, pll_bypass_o;
    wire         clock_out_pin_o, analog_pd_o, internal_rc_en_o, sysosc_en_o;
    wire         watchdog_osc_en_o, brownout_monitor_en_o, wd_irq_o;
    int          error_cnt = 0, tests_run = 0, seed = 32'h4266, k, n, j, c;
    int          fi_cnt = 0, st_cnt = 0, tk_cnt = 0;
    logic [31:0] mdl [logic [7:0]];

    cprc_top cprc_top_inst (
        .mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .reset_pin_n_i,
        .brownout_i, .internal_rc_clock_i, .sysosc_clock_i, .watchdog_osc_i, .start_pin_i,
        .sleep_req_i, .irq_pending_i, .chip_rst_o, .flash_init_o, .boot_addr_o,
        .core_clk_en_o, .main_sel_o, .pll_pd_o, .pll_bypass_o, .pll_msel_o, .pll_psel_o,
        .clock_out_pin_o, .periph_clk_en_o, .periph_tick_o, .analog_pd_o, .internal_rc_en_o,
        .sysosc_en_o, .watchdog_osc_en_o, .brownout_monitor_en_o, .start_irq_o, .wd_irq_o
    );

    initial begin
        forever #20 mclk_i = ~mclk_i;
    end

    // rc source at a quarter of the system clock, so the synchroniser sees every level
    always @(posedge mclk_i) begin
        if (irc_run) begin
            irc_ph <= irc_ph + 2'h1;
            internal_rc_clock_i <= irc_ph[1];
        end
        if (flash_init_o === 1'b1) fi_cnt <= fi_cnt + 1;
        if (periph_tick_o[0] === 1'b1) tk_cnt <= tk_cnt + 1;
        if (start_irq_o !== 13'h0) begin
            st_cnt <= st_cnt + 1;
            st_last <= start_irq_o;
        end
    end

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        tests_run++;
        if (s !== x) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, x, s);
        end
    endtask

    function automatic logic [31:0] fold(input logic [7:0] a, input logic [31:0] d);
        case (a)
            `CPRC_MAINSEL, `CPRC_CLKOUTSEL: return d & 32'h3;
            `CPRC_PLLCTRL: return d & 32'hff;
            `CPRC_STARTEN: return d & 32'h1fff;
            `CPRC_WDTC: return (d[23:0] < `CPRC_WDTC_MIN) ? {8'h0, `CPRC_WDTC_MIN} : d & 32'hffffff;
            default: return d & 32'hffff;
        endcase
    endfunction

    task automatic mreset();
        mdl.delete();
        mdl[`CPRC_MAINSEL] = 32'h0;
        mdl[`CPRC_CLKEN] = 32'hffff;
        mdl[`CPRC_WDTC] = 32'hff;
        mdl[8'h40] = 32'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        if (a inside {`CPRC_MAINSEL, `CPRC_PLLCTRL, `CPRC_CLKOUTSEL, `CPRC_CLKEN, `CPRC_PERDIV,
                      `CPRC_STARTEN, `CPRC_WDTC}) mdl[a] = fold(a, d);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        d = rdata_o;
    endtask

    task automatic chk_regs();
        foreach (mdl[a]) begin
            rd(a, v);
            chk($sformatf("reg_%h", a), v, mdl[a]);
        end
    endtask

    task automatic feed();
        wr(`CPRC_WDFEED, {24'h0, `CPRC_FEED_1});
        wr(`CPRC_WDFEED, {24'h0, `CPRC_FEED_2});
    endtask

    task automatic sleep_go();
        @(posedge mclk_i);
        sleep_req_i <= 1'b1;
        @(posedge mclk_i);
        sleep_req_i <= 1'b0;
        repeat (4) @(negedge mclk_i);
    endtask

    task automatic wake_wait();
        for (n = 0; n < 10 && core_clk_en_o !== 1'b1; n++) @(negedge mclk_i);
        @(posedge mclk_i);
    endtask

    // counts edges until a chip reset starts, then waits for it to end
    task automatic rst_cycle(output int cnt);
        for (cnt = 0; cnt < 6000 && chip_rst_o !== 1'b1; cnt++) @(posedge mclk_i);
        for (n = 0; n < 20 && chip_rst_o !== 1'b0; n++) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask

    task automatic final_report();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge mclk_i);
        error_cnt++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        for (n = 0; n < 20 && chip_rst_o !== 1'b0; n++) @(posedge mclk_i);
        @(negedge mclk_i);
        chk("reset_out", {main_sel_o, pll_pd_o, pll_bypass_o, boot_addr_o[0]}, 5'b00110);
        mreset();
        chk_regs();
        rd(`CPRC_RSTSTAT, v);
        chk("por_flag", v, 32'h1);
        for (k = 0; k < 4; k++) begin
            e = {24'h0, 1'b1, 2'(k), (k == 0) ? 5'h0 : (k == 3) ? 5'h1f : 5'($random(seed))};
            wr(`CPRC_PLLCTRL, e);
            wr(`CPRC_MAINSEL, {$random(seed)} % 3);
            repeat (2) @(negedge mclk_i);
            chk("pll_cfg", {pll_pd_o, pll_psel_o, pll_msel_o}, {1'b0, e[6:0]});
            chk("main_sel", main_sel_o, mdl[`CPRC_MAINSEL]);
        end
        rd(`CPRC_PLLSTAT, v);
        chk("pll_unlocked", v[0], 0);
        repeat (2500) @(posedge mclk_i);
        rd(`CPRC_PLLSTAT, v);
        chk("pll_locked", v[0], 1);
        wr(`CPRC_MAINSEL, `CPRC_SRC_PLL);
        sysosc_clock_i <= 1'b1;
        for (k = 0; k < 3; k++) begin
            wr(`CPRC_CLKOUTSEL, k);
            repeat (6) @(negedge mclk_i);
            chk("clock_out_pin", clock_out_pin_o, k == 1);
        end
        @(posedge mclk_i);
        watchdog_osc_i <= 1'b1;
        repeat (6) @(negedge mclk_i);
        chk("clock_out_pin_wdo", clock_out_pin_o, 1);
        e = $random(seed) & 32'hffff;
        wr(`CPRC_CLKEN, e);
        repeat (2) @(negedge mclk_i);
        chk("clk_en", periph_clk_en_o, e);
        wr(`CPRC_CLKEN, 32'hffff);
        for (k = 1; k >= 0; k--) begin
            wr(`CPRC_PERDIV, k);
            repeat (4) @(posedge mclk_i);
            j = tk_cnt;
            repeat (32) @(posedge mclk_i);
            chk("div_tick", tk_cnt > j, k);
        end
        chk_regs();
        k = {$random(seed)} % 13;
        wr(`CPRC_STARTEN, 1 << k);
        for (j = 0; j < 2; j++) begin
            c = st_cnt;
            start_pin_i[(k + j) % 13] <= 1'b1;
            repeat (8) @(posedge mclk_i);
            start_pin_i[(k + j) % 13] <= 1'b0;
            chk("start_irq", {st_cnt - c, st_last}, {j == 0, 13'h1 << k});
        end
        wr(`CPRC_PCON, 32'h30);
        sleep_go();
        chk("sleep", {core_clk_en_o, analog_pd_o, sysosc_en_o, watchdog_osc_en_o,
                      periph_clk_en_o}, 32'h3ffff);
        @(posedge mclk_i);
        irq_pending_i <= 1'b1;
        wake_wait();
        irq_pending_i <= 1'b0;
        chk("sleep_wake", core_clk_en_o, 1);
        wr(`CPRC_MAINSEL, `CPRC_SRC_IRC);
        wr(`CPRC_PCON, 32'h2d);
        sleep_go();
        chk("deep", {core_clk_en_o, analog_pd_o, brownout_monitor_en_o, sysosc_en_o,
                     watchdog_osc_en_o, periph_clk_en_o}, 32'hd0000);
        @(posedge mclk_i);
        start_pin_i[k] <= 1'b1;
        wake_wait();
        start_pin_i[k] <= 1'b0;
        chk("deep_wake", core_clk_en_o, 1);
        wr(`CPRC_WDTC, 32'h10);
        rd(`CPRC_WDTC, v);
        chk("wdtc_min", v, 32'hff);
        wr(`CPRC_WDMOD, 32'h3);
        feed();
        wr(`CPRC_WDFEED, 32'h12);
        for (n = 0; n < 6 && wd_irq_o !== 1'b1; n++) @(negedge mclk_i);
        chk("bad_feed_irq", {wd_irq_o, chip_rst_o}, 2'b10);
        rd(`CPRC_WDMOD, v);
        chk("wd_flag", v[2], 1);
        wr(`CPRC_WDMOD, 32'h9);
        irc_run <= 1'b1;
        feed();
        repeat (200) @(posedge mclk_i);
        rd(`CPRC_WDTV, v);
        chk("wd_src_wdo", {wd_irq_o, v[23:0]}, 32'hff);
        wr(`CPRC_WDMOD, 32'h1);
        feed();
        j = fi_cnt;
        rst_cycle(c);
        irc_run <= 1'b0;
        chk("wd_timeout", c >= 4076 && c <= 4116, 1);
        chk("after_rst", {main_sel_o, pll_pd_o, pll_bypass_o, internal_rc_en_o}, 5'b00111);
        chk("flash_init", fi_cnt - j, 1);
        rd(`CPRC_RSTSTAT, v);
        chk("wd_rst_flag", v, 32'h5);
        mreset();
        chk_regs();
        wr(`CPRC_RSTSTAT, 32'hf);
        for (k = 0; k < 2; k++) begin
            reset_pin_n_i <= k[0];
            brownout_i <= k[0];
            repeat (2) @(posedge mclk_i);
            reset_pin_n_i <= 1'b1;
            brownout_i <= 1'b0;
            rst_cycle(c);
            rd(`CPRC_RSTSTAT, v);
            chk("src_flag", v, k ? 32'ha : 32'h2);
        end
        final_report();
    end
endmodule // cprc_top_bench
`default_nettype wire
